//--- hdl/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
// three-stage synchroniser; output changes once stages two and three agree
module pin_sync #(
    parameter int width = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [width-1:0] async_i,
    output logic [width-1:0] sync_o
);
    logic [width-1:0] s1_q;
    logic [width-1:0] s2_q;
    logic [width-1:0] s3_q;

    // a zero-wide chain has nothing to carry
    if (width < 1) begin : g_width_check
        $error("pin_sync needs a width of at least one");
    end

    // capture chain
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // accept bits whose last two stages agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_o <= '0;
        end else begin
            for (int i = 0; i < width; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    sync_o[i] <= s3_q[i];
                end
            end
        end
    end
endmodule : pin_sync
`default_nettype wire

//--- hdl/wavegen_pkg.sv
package wavegen_pkg;

    // register offsets (byte addresses, one word each)
    localparam logic [3:0] shutdown_source_enable_off = 4'h0;
    localparam logic [3:0] output_steering_control_off = 4'h4;
    localparam logic [3:0] generator_clock_select_off = 4'h8;
    localparam logic [3:0] generator_input_select_off = 4'hC;

    // reset values
    localparam logic [7:0] shutdown_source_enable_rst = 8'h00;
    localparam logic [7:0] output_steering_control_rst = 8'h00;
    localparam logic [7:0] generator_clock_select_rst = 8'h00;
    localparam logic [7:0] generator_input_select_rst = 8'h00;

    // field positions
    localparam int shutdown_enable_width = 5;
    localparam int steer_enable_lsb = 0;
    localparam int override_value_lsb = 4;
    localparam int clock_select_bit = 0;
    localparam int restart_enable_bit = 3;
    localparam int shutdown_status_bit = 7;

    // generator modes
    localparam logic [2:0] mode_steering = 3'h0;
    localparam logic [2:0] mode_sync_steering = 3'h1;

    // fast oscillator rate
    localparam int fast_internal_oscillator_mhz = 16;

    // input select codes
    typedef enum logic [3:0] {
        sel_dedicated_input = 4'h0,
        sel_capture_compare1 = 4'h1,
        sel_capture_compare2 = 4'h2,
        sel_pwm3 = 4'h3,
        sel_pwm4 = 4'h4,
        sel_pwm5 = 4'h5,
        sel_pwm6 = 4'h6,
        sel_numeric_oscillator = 4'h7,
        sel_comparator1 = 4'h8,
        sel_comparator2 = 4'h9,
        sel_logic_cell1 = 4'hA,
        sel_logic_cell2 = 4'hB,
        sel_logic_cell3 = 4'hC,
        sel_logic_cell4 = 4'hD
    } input_source_select_type;

    // peripheral signals that feed the block
    typedef struct packed {
        logic generator_dedicated_input;
        logic [1:0] capture_compare;
        logic [3:0] pwm;
        logic numeric_oscillator;
        logic [1:0] comparator;
        logic [3:0] logic_cell;
        logic period_timer_postscaled;
        logic generator_pin_route;
    } source_bus_type;

endpackage : wavegen_pkg

//--- hdl/wavegen_steer.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - pin shutdown enable gates routed input pin
// - timer enable gates postscaled timer shutdown
// - comparator one enable gates its shutdown
// - comparator two enable gates its shutdown
// - logic cell two enable gates shutdown
// - upper three enable bits read zero
// - steered output carries data with polarity
// - unsteered output carries its override bit while hold_override_q is low
// - steering register acts only in 00x
// - synchronous mode buffers steering enables
// - clock select picks fast oscillator or system
// - codes one to seven pick timers' outputs
// - codes eight to thirteen comparators, cells
// - reserved codes none; zero dedicated input
// - mode 000 steering, 001 synchronous steering
// - auto restart clears status, waits rising edge
module wavegen_steer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire wavegen_pkg::source_bus_type src_i,
    input wire logic [2:0] mode_i,
    input wire logic [3:0] output_polarity_i,
    input wire logic restart_enable_i,
    input wire logic shutdown_clear_i,
    output logic [3:0] out_o,
    output logic shutdown_o,
    output logic fast_clock_select_o,
    output logic generator_data_waveform_o
);
    logic [7:0] shutdown_source_enable_q;
    logic [7:0] output_steering_control_q;
    logic [7:0] generator_clock_select_q;
    logic [7:0] generator_input_select_q;
    logic [3:0] active_steer_q;
    logic data_prev_q;
    logic shutdown_q;
    logic hold_override_q;
    wavegen_pkg::source_bus_type src_s;
    logic data_d;
    logic shutdown_src_d;
    logic steer_mode;
    logic data_rise;
    logic bus_req;
    logic wr_low;
    logic [7:0] rd_d;

    // pins and peripheral levels enter through the three-stage chain
    pin_sync #(.width($bits(wavegen_pkg::source_bus_type))) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(src_i),
        .sync_o(src_s)
    );

    // data source multiplexer
    function automatic logic pick_source(input logic [3:0] code,
                                         input wavegen_pkg::source_bus_type s);
        logic r;
        r = 1'b0;
        case (code)
            wavegen_pkg::sel_dedicated_input: r = s.generator_dedicated_input;
            wavegen_pkg::sel_capture_compare1: r = s.capture_compare[0];
            wavegen_pkg::sel_capture_compare2: r = s.capture_compare[1];
            wavegen_pkg::sel_pwm3: r = s.pwm[0];
            wavegen_pkg::sel_pwm4: r = s.pwm[1];
            wavegen_pkg::sel_pwm5: r = s.pwm[2];
            wavegen_pkg::sel_pwm6: r = s.pwm[3];
            wavegen_pkg::sel_numeric_oscillator: r = s.numeric_oscillator;
            wavegen_pkg::sel_comparator1: r = s.comparator[0];
            wavegen_pkg::sel_comparator2: r = s.comparator[1];
            wavegen_pkg::sel_logic_cell1: r = s.logic_cell[0];
            wavegen_pkg::sel_logic_cell2: r = s.logic_cell[1];
            wavegen_pkg::sel_logic_cell3: r = s.logic_cell[2];
            wavegen_pkg::sel_logic_cell4: r = s.logic_cell[3];
            default: r = 1'b0;
        endcase
        return r;
    endfunction : pick_source

    // source selection and enabled shutdown sources
    always_comb begin
        data_d = pick_source(generator_input_select_q[3:0], src_s);
        shutdown_src_d = (shutdown_source_enable_q[0] & src_s.generator_pin_route)
            | (shutdown_source_enable_q[1] & src_s.period_timer_postscaled)
            | (shutdown_source_enable_q[2] & src_s.comparator[0])
            | (shutdown_source_enable_q[3] & src_s.comparator[1])
            | (shutdown_source_enable_q[4] & src_s.logic_cell[1]);
    end

    assign data_rise = data_d & ~data_prev_q;
    assign steer_mode = (mode_i == wavegen_pkg::mode_steering)
        || (mode_i == wavegen_pkg::mode_sync_steering);
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_low = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

    // register writes land at the acknowledge edge, low byte lane only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shutdown_source_enable_q <= wavegen_pkg::shutdown_source_enable_rst;
            output_steering_control_q <= wavegen_pkg::output_steering_control_rst;
            generator_clock_select_q <= wavegen_pkg::generator_clock_select_rst;
            generator_input_select_q <= wavegen_pkg::generator_input_select_rst;
        end else if (wr_low) begin
            case (wb_adr_i)
                wavegen_pkg::shutdown_source_enable_off:
                    shutdown_source_enable_q <= {3'h0, wb_dat_i[4:0]};
                wavegen_pkg::output_steering_control_off:
                    output_steering_control_q <= wb_dat_i[7:0];
                wavegen_pkg::generator_clock_select_off:
                    generator_clock_select_q <= {7'h00, wb_dat_i[0]};
                wavegen_pkg::generator_input_select_off:
                    generator_input_select_q <= {4'h0, wb_dat_i[3:0]};
                default: ;
            endcase
        end
    end

    // read mux
    always_comb begin
        case (wb_adr_i)
            wavegen_pkg::shutdown_source_enable_off: rd_d = shutdown_source_enable_q;
            wavegen_pkg::output_steering_control_off: rd_d = output_steering_control_q;
            wavegen_pkg::generator_clock_select_off: rd_d = generator_clock_select_q;
            wavegen_pkg::generator_input_select_off: rd_d = generator_input_select_q;
            default: rd_d = 8'h00;
        endcase
    end

    // single-wait-state ack, read data registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? {24'h00_0000, rd_d} : 32'h0000_0000;
        end
    end

    // active steering enables: immediate in 000, buffered in 001
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_steer_q <= 4'h0;
        end else if (mode_i != wavegen_pkg::mode_sync_steering) begin
            active_steer_q <= output_steering_control_q[3:0];
        end else if (data_rise) begin
            active_steer_q <= output_steering_control_q[3:0];
        end
    end

    // shutdown status; a new source wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shutdown_q <= 1'b0;
            hold_override_q <= 1'b0;
            data_prev_q <= 1'b0;
        end else begin
            data_prev_q <= data_d;
            if (shutdown_src_d) begin
                shutdown_q <= 1'b1;
                hold_override_q <= 1'b1;
            end else if (shutdown_q && (restart_enable_i || shutdown_clear_i)) begin
                shutdown_q <= 1'b0;
            end else if (!shutdown_q && hold_override_q && data_rise) begin
                hold_override_q <= 1'b0;
            end
        end
    end

    // output steering and status outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_o <= 4'h0;
            shutdown_o <= 1'b0;
            fast_clock_select_o <= 1'b0;
            generator_data_waveform_o <= 1'b0;
        end else begin
            shutdown_o <= shutdown_q;
            fast_clock_select_o <= generator_clock_select_q[0];
            generator_data_waveform_o <= data_d;
            for (int i = 0; i < 4; i++) begin
                if (hold_override_q || !steer_mode) begin
                    out_o[i] <= data_d ^ output_polarity_i[i];
                end else if (active_steer_q[i]) begin
                    out_o[i] <= data_d ^ output_polarity_i[i];
                end else begin
                    out_o[i] <= output_steering_control_q[4+i];
                end
            end
        end
    end

    // checks
    property p_unsteered_override;
        @(posedge clk_i) disable iff (rst_i)
        (steer_mode && !hold_override_q && !active_steer_q[0]
            && $stable(mode_i)) |=> out_o[0] == $past(output_steering_control_q[4]);
    endproperty
    a_unsteered_override: assert property (p_unsteered_override) else $error("override");
    property p_steered;
        @(posedge clk_i) disable iff (rst_i)
        (steer_mode && !hold_override_q && active_steer_q[1])
            |=> out_o[1] == ($past(data_d) ^ $past(output_polarity_i[1]));
    endproperty
    a_steered: assert property (p_steered) else $error("steered");
    property p_sync_hold;
        @(posedge clk_i) disable iff (rst_i)
        (mode_i == wavegen_pkg::mode_sync_steering && !data_rise) |=> $stable(active_steer_q);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("sync hold");
    property p_sync_load;
        @(posedge clk_i) disable iff (rst_i)
        (mode_i == wavegen_pkg::mode_sync_steering && data_rise)
            |=> active_steer_q == $past(output_steering_control_q[3:0]);
    endproperty
    a_sync_load: assert property (p_sync_load) else $error("sync load");
    property p_upper_zero;
        @(posedge clk_i) disable iff (rst_i) shutdown_source_enable_q[7:5] == 3'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits");
    property p_pin_shutdown;
        @(posedge clk_i) disable iff (rst_i)
        (shutdown_source_enable_q[0] && src_s.generator_pin_route) |=> shutdown_q;
    endproperty
    a_pin_shutdown: assert property (p_pin_shutdown) else $error("pin shutdown");
    property p_cmp1_shutdown;
        @(posedge clk_i) disable iff (rst_i)
        (shutdown_source_enable_q[2] && src_s.comparator[0]) |=> ##1 shutdown_o;
    endproperty
    a_cmp1_shutdown: assert property (p_cmp1_shutdown) else $error("cmp shutdown");
    property p_no_source;
        @(posedge clk_i) disable iff (rst_i)
        (!shutdown_src_d && !shutdown_q) |=> !shutdown_q;
    endproperty
    a_no_source: assert property (p_no_source) else $error("spurious");
    property p_restart;
        @(posedge clk_i) disable iff (rst_i)
        (shutdown_q && restart_enable_i && !shutdown_src_d) |=> !shutdown_q;
    endproperty
    a_restart: assert property (p_restart) else $error("restart");
    property p_clock_sel;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> fast_clock_select_o == $past(generator_clock_select_q[0]);
    endproperty
    a_clock_sel: assert property (p_clock_sel) else $error("clock select");
    property p_timer_shutdown;
        @(posedge clk_i) disable iff (rst_i)
        (shutdown_source_enable_q[1] && src_s.period_timer_postscaled) |=> shutdown_q;
    endproperty
    a_timer_shutdown: assert property (p_timer_shutdown) else $error("timer shutdown");
    property p_cmp2_shutdown;
        @(posedge clk_i) disable iff (rst_i)
        (shutdown_source_enable_q[3] && src_s.comparator[1]) |=> shutdown_q;
    endproperty
    a_cmp2_shutdown: assert property (p_cmp2_shutdown) else $error("cmp2 shutdown");
    property p_cell_shutdown;
        @(posedge clk_i) disable iff (rst_i)
        (shutdown_source_enable_q[4] && src_s.logic_cell[1]) |=> shutdown_q;
    endproperty
    a_cell_shutdown: assert property (p_cell_shutdown) else $error("cell shutdown");
    property p_masked_sources;
        @(posedge clk_i) disable iff (rst_i)
        (shutdown_source_enable_q[4:0] == 5'h00 && !shutdown_q) |=> !shutdown_q;
    endproperty
    a_masked_sources: assert property (p_masked_sources) else $error("masked");
    property p_plain_steer_load;
        @(posedge clk_i) disable iff (rst_i)
        (mode_i == wavegen_pkg::mode_steering) |=> active_steer_q == $past(output_steering_control_q[3:0]);
    endproperty
    a_plain_steer_load: assert property (p_plain_steer_load) else $error("plain load");
    property p_reserved_code;
        @(posedge clk_i) disable iff (rst_i)
        (generator_input_select_q[3:1] == 3'h7) |=> !generator_data_waveform_o;
    endproperty
    a_reserved_code: assert property (p_reserved_code) else $error("reserved code");
    property p_hold_release;
        @(posedge clk_i) disable iff (rst_i)
        (!shutdown_q && hold_override_q && data_rise && !shutdown_src_d) |=> !hold_override_q;
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("hold release");
    property p_other_mode;
        @(posedge clk_i) disable iff (rst_i)
        !steer_mode |=> out_o == ($past({4{data_d}}) ^ $past(output_polarity_i));
    endproperty
    a_other_mode: assert property (p_other_mode) else $error("other mode");
    c_shutdown: cover property (@(posedge clk_i) disable iff (rst_i) $rose(shutdown_q));
    c_sync_load: cover property (@(posedge clk_i) disable iff (rst_i)
        mode_i == wavegen_pkg::mode_sync_steering && data_rise);
    c_ack: cover property (@(posedge clk_i) disable iff (rst_i) wb_ack_o);
    c_restart: cover property (@(posedge clk_i) disable iff (rst_i) $fell(shutdown_q));
    c_hold_release: cover property (@(posedge clk_i) disable iff (rst_i) $fell(hold_override_q));
endmodule : wavegen_steer
`default_nettype wire

//--- tb/src_model.sv
`timescale 1ns/1ns
`default_nettype none
// peripheral sources feeding the block; levels move off the system edge
module src_model (
    input wire logic clk_i,
    input wire wavegen_pkg::source_bus_type level_i,
    output var wavegen_pkg::source_bus_type src_o
);
    // falling-edge update, so the block must resynchronise every level
    always_ff @(negedge clk_i) begin
        src_o <= level_i;
    end
endmodule : src_model
`default_nettype wire

//--- tb/waveform_gen_steer_shutdown_select_bench.sv
`timescale 1ns/1ns
`default_nettype none
module waveform_gen_steer_shutdown_select_bench;
    logic clk_i;
    logic rst_i;
    logic req;
    logic we;
    logic [3:0] adr;
    logic [31:0] dat;
    logic [31:0] rdat;
    logic ack;
    wavegen_pkg::source_bus_type lvl;
    wavegen_pkg::source_bus_type src;
    logic [2:0] mode;
    logic [3:0] pol;
    logic ren;
    logic clr;
    logic [3:0] out;
    logic sd;
    logic fcs;
    logic wave;
    logic [7:0] r;
    int err_count = 0;
    int n_tests = 0;

    src_model peer (.clk_i(clk_i), .level_i(lvl), .src_o(src));

    wavegen_steer dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .src_i(src), .mode_i(mode),
        .output_polarity_i(pol), .restart_enable_i(ren), .shutdown_clear_i(clr),
        .out_o(out), .shutdown_o(sd), .fast_clock_select_o(fcs),
        .generator_data_waveform_o(wave)
    );

    // free-running system clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // classic cycle: hold until ack, take data there, then release
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        req <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h00_0000, d};
        @(posedge clk_i);
        while (ack !== 1'b1) begin
            @(posedge clk_i);
        end
        r = rdat[7:0];
        req <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(r, e);
    endtask : rd

    // let the source synchroniser and output flops settle
    task automatic st;
        repeat (8) @(posedge clk_i);
    endtask : st

    // one source high for an input select code
    function automatic wavegen_pkg::source_bus_type one_src(input logic [3:0] c);
        wavegen_pkg::source_bus_type s;
        s = '0;
        case (c)
            4'h0: s.generator_dedicated_input = 1'b1;
            4'h1, 4'h2: s.capture_compare[c - 4'h1] = 1'b1;
            4'h3, 4'h4, 4'h5, 4'h6: s.pwm[c - 4'h3] = 1'b1;
            4'h7: s.numeric_oscillator = 1'b1;
            4'h8, 4'h9: s.comparator[c - 4'h8] = 1'b1;
            4'ha, 4'hb, 4'hc, 4'hd: s.logic_cell[c - 4'ha] = 1'b1;
            default: ;
        endcase
        return s;
    endfunction : one_src

    // one shutdown source high, in enable bit order
    function automatic wavegen_pkg::source_bus_type sd_src(input int k);
        wavegen_pkg::source_bus_type s;
        s = '0;
        case (k)
            0: s.generator_pin_route = 1'b1;
            1: s.period_timer_postscaled = 1'b1;
            2: s.comparator[0] = 1'b1;
            3: s.comparator[1] = 1'b1;
            default: s.logic_cell[1] = 1'b1;
        endcase
        return s;
    endfunction : sd_src

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk_i);
        chk(8'h00, 8'hff);
        results();
    end

    // main sequence
    initial begin
        rst_i = 1'b1;
        req = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        dat = 32'h0000_0000;
        lvl = '0;
        mode = 3'h0;
        pol = 4'h0;
        ren = 1'b0;
        clr = 1'b0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(wavegen_pkg::shutdown_source_enable_off, 8'h00);
        rd(wavegen_pkg::output_steering_control_off, 8'h00);
        rd(wavegen_pkg::generator_clock_select_off, 8'h00);
        rd(wavegen_pkg::generator_input_select_off, 8'h00);
        rd(4'h2, 8'h00);
        chk({3'h0, sd, out}, 8'h00);
        wr(wavegen_pkg::shutdown_source_enable_off, 8'hff);
        rd(wavegen_pkg::shutdown_source_enable_off, 8'h1f);
        wr(wavegen_pkg::generator_clock_select_off, 8'hff);
        rd(wavegen_pkg::generator_clock_select_off, 8'h01);
        st();
        chk({7'h00, fcs}, 8'h01);
        wr(wavegen_pkg::generator_clock_select_off, 8'h00);
        st();
        chk({7'h00, fcs}, 8'h00);
        wr(wavegen_pkg::generator_input_select_off, 8'hff);
        rd(wavegen_pkg::generator_input_select_off, 8'h0f);
        wr(wavegen_pkg::output_steering_control_off, 8'h5c);
        rd(wavegen_pkg::output_steering_control_off, 8'h5c);
        wr(wavegen_pkg::shutdown_source_enable_off, 8'h00);
        $display("register test done");
        // every select code: lone source high, then all others high
        for (int c = 0; c < 16; c++) begin
            wr(wavegen_pkg::generator_input_select_off, 8'(c));
            lvl <= one_src(4'(c));
            st();
            chk({7'h00, wave}, {7'h00, c < 14});
            lvl <= ~one_src(4'(c));
            st();
            chk({7'h00, wave}, 8'h00);
        end
        $display("input select test done");
        // plain steering: a and b overridden, c and d steered, d inverted
        wr(wavegen_pkg::generator_input_select_off, 8'h00);
        pol <= 4'h8;
        wr(wavegen_pkg::output_steering_control_off, 8'h5c);
        lvl <= one_src(4'h0);
        st();
        chk({4'h0, out}, 8'h05);
        lvl <= '0;
        st();
        chk({4'h0, out}, 8'h09);
        mode <= 3'h2;
        st();
        chk({4'h0, out}, 8'h08);
        // synchronous steering: new enables wait for a data rising edge
        mode <= 3'h1;
        wr(wavegen_pkg::output_steering_control_off, 8'h00);
        lvl <= one_src(4'h0);
        st();
        chk({4'h0, out}, 8'h00);
        lvl <= '0;
        st();
        wr(wavegen_pkg::output_steering_control_off, 8'h0f);
        st();
        chk({4'h0, out}, 8'h00);
        lvl <= one_src(4'h0);
        st();
        chk({4'h0, out}, 8'h07);
        mode <= 3'h0;
        $display("steering test done");
        // each shutdown source ignored when disabled, obeyed when enabled
        ren <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            wr(wavegen_pkg::shutdown_source_enable_off, 8'h1f & ~(8'h01 << k));
            lvl <= sd_src(k);
            st();
            chk({7'h00, sd}, 8'h00);
            wr(wavegen_pkg::shutdown_source_enable_off, 8'h01 << k);
            st();
            chk({7'h00, sd}, 8'h01);
            lvl <= '0;
            st();
            chk({7'h00, sd}, 8'h00);
        end
        // without auto restart the status stays until software clears it
        ren <= 1'b0;
        lvl <= sd_src(4);
        st();
        lvl <= '0;
        st();
        chk({7'h00, sd}, 8'h01);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        st();
        chk({7'h00, sd}, 8'h00);
        lvl <= one_src(4'h0);
        st();
        chk({4'h0, out}, 8'h07);
        $display("shutdown test done");
        results();
    end
endmodule : waveform_gen_steer_shutdown_select_bench
`default_nettype wire
